// ### hdl/dgb_pkg.sv
// Package with offsets, field positions and reset values of the config bank.
package dgb_pkg;
  localparam logic [6:0] DGB_GENERAL_CONFIG_ADDR = 7'h04;
  localparam logic [6:0] DGB_BROADCAST_SELECT_ADDR = 7'h05;
  localparam logic [15:0] DGB_GENERAL_CONFIG_RESET = 16'h7f00;
  localparam logic [15:0] DGB_BROADCAST_SELECT_RESET = 16'hffff;
  localparam int DGB_REF_POWERDOWN_BIT = 14;
  localparam logic [15:0] DGB_GENERAL_CONFIG_FIXED_MASK = 16'hbf00;
  localparam logic [15:0] DGB_GENERAL_CONFIG_FIXED_VALUE = 16'h3f00;
  localparam logic [15:0] DGB_GENERAL_CONFIG_RW_MASK = 16'h40ff;
  localparam int DGB_CHANNELS = 16;
  localparam int DGB_PAIRS = 8;
endpackage

// ### hdl/dgb_config_bank.sv
// General configuration and broadcast selection registers with broadcast logic.
`timescale 1ns/1ns
`default_nettype none
module dgb_config_bank
  import dgb_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic broadcast_cmd_i,
  input wire logic [15:0] broadcast_value_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reference_powerdown_o,
  output logic reference_active_o,
  output logic [7:0] pair_differential_enable_o,
  output logic [15:0] channel_broadcast_enable_o,
  output logic [15:0] channel_update_o,
  output logic [15:0] channel_update_value_o,
  output logic broadcast_ignored_o
);

  // All registered state of the bank; every output is one of these fields.
  typedef struct packed {
    logic [15:0] general_config;
    logic [15:0] broadcast_select;
    logic [15:0] rdata;
    logic rvalid;
    logic powerdown;
    logic active;
    logic [7:0] differential;
    logic [15:0] update;
    logic [15:0] value;
    logic ignored;
  } dgb_state_s;

  dgb_state_s st;
  dgb_state_s next_st;

  // True when the index selects the general configuration register.
  function automatic logic dgb_is_general(
    input logic [6:0] addr
  );
    dgb_is_general = (addr == DGB_GENERAL_CONFIG_ADDR);
  endfunction

  // True when the index selects the broadcast selection register.
  function automatic logic dgb_is_select(
    input logic [6:0] addr
  );
    dgb_is_select = (addr == DGB_BROADCAST_SELECT_ADDR);
  endfunction

  // Keeps the writable bits and forces the reserved bits to their values.
  function automatic logic [15:0] dgb_fix_general(
    input logic [15:0] v
  );
    dgb_fix_general = (v & DGB_GENERAL_CONFIG_RW_MASK) |
                      DGB_GENERAL_CONFIG_FIXED_VALUE;
  endfunction

  // Reference power-down level held in a general configuration word.
  function automatic logic dgb_ref_down(
    input logic [15:0] cfg
  );
    dgb_ref_down = cfg[DGB_REF_POWERDOWN_BIT];
  endfunction

  // Differential enables of the eight channel pairs in a config word.
  function automatic logic [7:0] dgb_pairs_of(
    input logic [15:0] cfg
  );
    dgb_pairs_of = cfg[DGB_PAIRS-1:0];
  endfunction

  // True when at least one channel pair runs differentially.
  function automatic logic dgb_any_differential(
    input logic [15:0] cfg
  );
    dgb_any_differential = |dgb_pairs_of(cfg);
  endfunction

  // Read data for an index; unknown indices read as zero.
  function automatic logic [15:0] dgb_read_mux(
    input logic [6:0] addr,
    input logic [15:0] gen,
    input logic [15:0] sel
  );
    if (dgb_is_general(addr)) begin
      dgb_read_mux = gen;
    end else if (dgb_is_select(addr)) begin
      dgb_read_mux = sel;
    end else begin
      dgb_read_mux = 16'h0000;
    end
  endfunction

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.update = 16'h0000;
    next_st.ignored = 1'b0;

    // Register writes take effect at the edge that samples the strobe.
    if (reg_wr_i) begin
      if (dgb_is_general(reg_addr_i)) begin
        next_st.general_config =
          dgb_fix_general(reg_wdata_i);
      end else if (dgb_is_select(reg_addr_i)) begin
        next_st.broadcast_select = reg_wdata_i;
      end
    end

    // A read in the same cycle as a write returns the old contents.
    if (reg_rd_i) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = dgb_read_mux(
        reg_addr_i,
        st.general_config,
        st.broadcast_select
      );
    end

    // Broadcast uses the register values from before a same-cycle write.
    if (broadcast_cmd_i) begin
      if (dgb_any_differential(st.general_config)) begin
        next_st.ignored = 1'b1;
      end else begin
        next_st.update = st.broadcast_select;
        if (|st.broadcast_select) begin
          next_st.value = broadcast_value_i;
        end
      end
    end

    // Decoded control levels follow the new configuration word.
    next_st.powerdown =
      dgb_ref_down(next_st.general_config);
    next_st.active =
      ~dgb_ref_down(next_st.general_config);
    next_st.differential =
      dgb_pairs_of(next_st.general_config);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st.general_config <= DGB_GENERAL_CONFIG_RESET;
      st.broadcast_select <= DGB_BROADCAST_SELECT_RESET;
      st.rdata <= 16'h0000;
      st.rvalid <= 1'b0;
      st.powerdown <=
        DGB_GENERAL_CONFIG_RESET[DGB_REF_POWERDOWN_BIT];
      st.active <=
        ~DGB_GENERAL_CONFIG_RESET[DGB_REF_POWERDOWN_BIT];
      st.differential <=
        DGB_GENERAL_CONFIG_RESET[DGB_PAIRS-1:0];
      st.update <= 16'h0000;
      st.value <= 16'h0000;
      st.ignored <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Register bus answer.
  assign reg_rdata_o = st.rdata;

  assign reg_rvalid_o = st.rvalid;

  // Reference control levels.
  assign reference_powerdown_o = st.powerdown;

  assign reference_active_o = st.active;

  // Channel pair mode.
  assign pair_differential_enable_o = st.differential;

  // Broadcast participation and results.
  assign channel_broadcast_enable_o = st.broadcast_select;

  assign channel_update_o = st.update;

  assign channel_update_value_o = st.value;

  assign broadcast_ignored_o = st.ignored;

endmodule
`default_nettype wire

// ### dv/dgb_config_bank_asserts.sv
// Port assertions for the config bank.
`timescale 1ns/1ns
`default_nettype none
module dgb_chk (input wire logic clk_i, sys_rst_i, reg_wr_i, broadcast_cmd_i,
  input wire logic [6:0] reg_addr_i, input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] broadcast_value_i, channel_broadcast_enable_o,
  input wire logic [15:0] channel_update_o, channel_update_value_o,
  input wire logic [7:0] pair_differential_enable_o,
  input wire logic reference_powerdown_o, broadcast_ignored_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire g = reg_wr_i & reg_addr_i == 7'h4, b = reg_wr_i & reg_addr_i == 7'h5;
  wire c = broadcast_cmd_i, s = c & !pair_differential_enable_o;
  wire [15:0] u = channel_update_o, v = channel_update_value_o;
  ref_wr_a: assert property (g |=>
    reference_powerdown_o == $past(reg_wdata_i[14])) else $error("ref");
  pair_wr_a: assert property (g |=>
    pair_differential_enable_o == $past(reg_wdata_i[7:0])) else $error("pair");
  sel_wr_a: assert property (b |=>
    channel_broadcast_enable_o == $past(reg_wdata_i)) else $error("sel");
  sel_hold_a: assert property (!b |=>
    $stable(channel_broadcast_enable_o)) else $error("hold");
  bc_sel_a: assert property (s |=>
    u == $past(channel_broadcast_enable_o)) else $error("upd");
  bc_val_a: assert property (s && channel_broadcast_enable_o != 0 |=>
    v == $past(broadcast_value_i)) else $error("val");
  bc_drop_a: assert property (c && !s |=>
    broadcast_ignored_o && !u && $stable(v)) else $error("drop");
  bc_idle_a: assert property (!c |=>
    !u && !broadcast_ignored_o) else $error("idle");
endmodule
bind dgb_config_bank dgb_chk chk (.*);
`default_nettype wire

// ### dv/dgb_host.sv
// Host model issuing register and broadcast requests.
`timescale 1ns/1ns
`default_nettype none
module dgb_host (input wire logic clk_i, output logic [2:0] k_o,
  output logic [6:0] a_o, output logic [15:0] d_o);
  initial {k_o, a_o, d_o} = '0;
  task op(input logic [2:0] k, input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i) #1 {k_o, a_o, d_o} = {k, a, d};
    @(posedge clk_i) #1 {k_o, a_o, d_o} = {3'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Testbench for the config bank.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i = 0, sys_rst_i = 1;
  wire reg_wr_i, reg_rd_i, broadcast_cmd_i, reg_rvalid_o, broadcast_ignored_o;
  wire reference_powerdown_o, reference_active_o;
  wire [6:0] reg_addr_i;
  wire [7:0] pair_differential_enable_o;
  wire [15:0] reg_wdata_i, reg_rdata_o, channel_update_o;
  wire [15:0] channel_update_value_o, channel_broadcast_enable_o;
  wire [15:0] broadcast_value_i = reg_wdata_i;
  int mismatches = 0, n_checks = 0;
  always #5 clk_i = ~clk_i;
  dgb_host h (.clk_i, .k_o({reg_wr_i, reg_rd_i, broadcast_cmd_i}),
    .a_o(reg_addr_i), .d_o(reg_wdata_i));
  dgb_config_bank uut (.*);
  task ck(input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin mismatches++; $display("BAD %0t %h", $time, g); end
  endtask
  task wrap_up;
    $display("%0d checks %0d mismatches", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin #5000 mismatches++; wrap_up; end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 sys_rst_i = 0;
    ck(channel_broadcast_enable_o, 16'hffff);
    ck(reference_powerdown_o, 16'h1);
    ck(pair_differential_enable_o, 16'h0);
    h.op(3'h6, 7'h04, 16'h80ff);
    ck(reg_rdata_o, 16'h7f00);
    ck(reg_rvalid_o, 16'h1);
    h.op(3'h2, 7'h04, 16'h0);
    ck(reg_rdata_o, 16'h3fff);
    ck(pair_differential_enable_o, 16'hff);
    ck(reference_powerdown_o, 16'h0);
    h.op(3'h1, 7'h00, 16'h1234);
    ck({reference_active_o, broadcast_ignored_o}, 16'h3);
    h.op(3'h4, 7'h04, 16'h0);
    h.op(3'h4, 7'h05, 16'ha5a5);
    h.op(3'h1, 7'h00, 16'h1234);
    ck(channel_update_o, 16'ha5a5);
    ck(channel_update_value_o, 16'h1234);
    h.op(3'h2, 7'h06, 16'h0);
    ck(reg_rdata_o, 16'h0);
    $display("register and broadcast test done");
    wrap_up;
  end
endmodule
`default_nettype wire
